// [verilog/txsym_top.sv]
// Transmit symbol pattern registers and symbol serialiser
`include "txsym_consts.svh"

module txsym_top (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // Register port
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdata,
  // Symbol request from the encoder
  input  wire logic       symReq,
  input  wire logic [1:0] symSel,
  // Serial symbol output
  output logic            symBusy,
  output logic            symBit,
  output logic            symBitStrobe,
  output logic            symDone,
  output logic            symRefused,
  output logic            scSel848,
  output logic            scOut
);

  // ========================================================
  // Registers
  txsym_pkg::txsym_rate_s  rate_q;
  txsym_pkg::txsym_len10_s len10_q;
  txsym_pkg::txsym_len32_s len32_q;
  logic [7:0] p0Hi_q;
  logic [7:0] p0Lo_q;
  logic [7:0] p1Hi_q;
  logic [7:0] p1Lo_q;
  logic [7:0] p2_q;
  logic [7:0] p3_q;
  logic [7:0] regRdata_q;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rate_q  <= `TXSYM_RESET_BYTE;
      len10_q <= `TXSYM_RESET_BYTE;
      len32_q <= `TXSYM_RESET_BYTE;
      p0Hi_q  <= `TXSYM_RESET_BYTE;
      p0Lo_q  <= `TXSYM_RESET_BYTE;
      p1Hi_q  <= `TXSYM_RESET_BYTE;
      p1Lo_q  <= `TXSYM_RESET_BYTE;
      p2_q    <= `TXSYM_RESET_BYTE;
      p3_q    <= `TXSYM_RESET_BYTE;
    end else if (regWr) begin
      case (regAddr)
        `TXSYM_ADDR_RATE:  rate_q  <= regWdata;
        `TXSYM_ADDR_P0_HI: p0Hi_q  <= regWdata;
        `TXSYM_ADDR_P0_LO: p0Lo_q  <= regWdata;
        `TXSYM_ADDR_P1_HI: p1Hi_q  <= regWdata;
        `TXSYM_ADDR_P1_LO: p1Lo_q  <= regWdata;
        `TXSYM_ADDR_P2:    p2_q    <= regWdata;
        `TXSYM_ADDR_P3:    p3_q    <= regWdata;
        `TXSYM_ADDR_LEN10: len10_q <= regWdata;
        `TXSYM_ADDR_LEN32: len32_q <= regWdata & `TXSYM_LEN32_MASK;
        default: ;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      regRdata_q <= `TXSYM_RESET_BYTE;
    end else if (regRd) begin
      case (regAddr)
        `TXSYM_ADDR_RATE:  regRdata_q <= rate_q;
        `TXSYM_ADDR_P0_HI: regRdata_q <= p0Hi_q;
        `TXSYM_ADDR_P0_LO: regRdata_q <= p0Lo_q;
        `TXSYM_ADDR_P1_HI: regRdata_q <= p1Hi_q;
        `TXSYM_ADDR_P1_LO: regRdata_q <= p1Lo_q;
        `TXSYM_ADDR_P2:    regRdata_q <= p2_q;
        `TXSYM_ADDR_P3:    regRdata_q <= p3_q;
        `TXSYM_ADDR_LEN10: regRdata_q <= len10_q;
        `TXSYM_ADDR_LEN32: regRdata_q <= len32_q;
        default:           regRdata_q <= `TXSYM_RESET_BYTE;
      endcase
    end else begin
      regRdata_q <= `TXSYM_RESET_BYTE;
    end
  end

  assign regRdata = regRdata_q;

  // ========================================================
  // Pattern and length selection
  logic [15:0] patOf [4];
  logic [3:0]  lenOf [4];
  logic        msbOf [4];

  assign patOf[0] = {p0Hi_q, p0Lo_q};
  assign patOf[1] = {p1Hi_q, p1Lo_q};
  assign patOf[2] = {8'h00, p2_q};
  assign patOf[3] = {8'h00, p3_q};
  assign lenOf[0] = len10_q.firstPatternLength;
  assign lenOf[1] = len10_q.secondPatternLength;
  assign lenOf[2] = {1'b0, len32_q.thirdPatternLength};
  assign lenOf[3] = {1'b0, len32_q.fourthPatternLength};

  // First bit sent is the top valid bit of each pattern
  for (genvar s = 0; s < 4; s++) begin : g_msb
    assign msbOf[s] = patOf[s][lenOf[s]];
  end

  logic [15:0] selPat;
  logic [3:0]  selLen;
  logic        selMsb;
  logic [2:0]  selCode;
  logic        selSc;
  logic        selRsvd;
  logic [10:0] selPeriod;

  assign selPat = patOf[symSel];
  assign selLen = lenOf[symSel];
  assign selMsb = msbOf[symSel];

  // Upper pair takes fields 7..4, lower pair fields 3..0
  assign selCode = symSel[1] ? rate_q.upperPairBitrateSel
                             : rate_q.lowerPairBitrateSel;
  assign selSc   = symSel[1] ? rate_q.upperPairSubcarrierSel
                             : rate_q.lowerPairSubcarrierSel;
  assign selRsvd = selCode < `TXSYM_CODE_26K;

  always_comb begin
    case (selCode)
      `TXSYM_CODE_26K:  selPeriod = 11'(`TXSYM_DIV_26K);
      `TXSYM_CODE_53K:  selPeriod = 11'(`TXSYM_DIV_53K);
      `TXSYM_CODE_106K: selPeriod = 11'(`TXSYM_DIV_106K);
      `TXSYM_CODE_212K: selPeriod = 11'(`TXSYM_DIV_212K);
      `TXSYM_CODE_424K: selPeriod = 11'(`TXSYM_DIV_424K);
      `TXSYM_CODE_848K: selPeriod = 11'(`TXSYM_DIV_848K);
      default:          selPeriod = 11'h001;
    endcase
  end

  // ========================================================
  // Serialiser
  txsym_pkg::txsym_state_e state_q;
  logic [15:0] patt_q;
  logic [3:0]  bitIdx_q;
  logic [3:0]  lenHeld_q;
  logic [10:0] period_q;
  logic [10:0] divCnt_q;
  logic        symBit_q;
  logic        symBitStrobe_q;
  logic        symDone_q;
  logic        symRefused_q;
  logic        scSel848_q;
  logic        symBusy_q;
  logic        accept;
  logic        bitEnd;

  assign accept = symReq && (state_q == txsym_pkg::TXSYM_IDLE) && !selRsvd;
  assign bitEnd = (state_q == txsym_pkg::TXSYM_SEND) && (divCnt_q == 11'h000);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= txsym_pkg::TXSYM_IDLE;
      symBusy_q <= 1'b0;
    end else begin
      unique case (state_q)
        txsym_pkg::TXSYM_IDLE: begin
          if (accept) begin
            state_q <= txsym_pkg::TXSYM_SEND;
            symBusy_q <= 1'b1;
          end
        end
        txsym_pkg::TXSYM_SEND: begin
          if (bitEnd && (bitIdx_q == 4'h0)) begin
            state_q <= txsym_pkg::TXSYM_DONE;
            symBusy_q <= 1'b0;
          end
        end
        txsym_pkg::TXSYM_DONE: state_q <= txsym_pkg::TXSYM_IDLE;
        default:               state_q <= txsym_pkg::TXSYM_IDLE;
      endcase
    end
  end

  // Pattern is latched so register writes cannot disturb a symbol in flight
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      patt_q     <= 16'h0000;
      lenHeld_q  <= 4'h0;
      period_q   <= 11'h001;
      scSel848_q <= 1'b0;
    end else if (accept) begin
      patt_q     <= selPat;
      lenHeld_q  <= selLen;
      period_q   <= selPeriod;
      scSel848_q <= selSc;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bitIdx_q       <= 4'h0;
      divCnt_q       <= 11'h000;
      symBit_q       <= 1'b0;
      symBitStrobe_q <= 1'b0;
    end else if (accept) begin
      bitIdx_q       <= selLen;
      divCnt_q       <= selPeriod - 11'h001;
      symBit_q       <= selMsb;
      symBitStrobe_q <= 1'b1;
    end else if (bitEnd && (bitIdx_q != 4'h0)) begin
      bitIdx_q       <= bitIdx_q - 4'h1;
      divCnt_q       <= period_q - 11'h001;
      symBit_q       <= patt_q[bitIdx_q - 4'h1];
      symBitStrobe_q <= 1'b1;
    end else begin
      if (state_q == txsym_pkg::TXSYM_SEND) begin
        divCnt_q <= divCnt_q - 11'h001;
      end
      if (state_q != txsym_pkg::TXSYM_SEND) begin
        symBit_q <= 1'b0;
      end
      symBitStrobe_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      symDone_q    <= 1'b0;
      symRefused_q <= 1'b0;
    end else begin
      symDone_q    <= bitEnd && (bitIdx_q == 4'h0);
      symRefused_q <= symReq && !accept;
    end
  end

  // ========================================================
  // Subcarrier square wave during a symbol
  logic [5:0] scCnt_q;
  logic       scOut_q;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      scCnt_q <= 6'h00;
      scOut_q <= 1'b0;
    end else if (state_q != txsym_pkg::TXSYM_SEND) begin
      scCnt_q <= 6'h00;
      scOut_q <= 1'b0;
    end else if (scCnt_q == 6'h00) begin
      scCnt_q <= scSel848_q ? 6'(`TXSYM_SCH_848K - 1)
                            : 6'(`TXSYM_SCH_424K - 1);
      scOut_q <= !scOut_q;
    end else begin
      scCnt_q <= scCnt_q - 6'h01;
    end
  end

  assign symBusy      = symBusy_q;
  assign symBit       = symBit_q;
  assign symBitStrobe = symBitStrobe_q;
  assign symDone      = symDone_q;
  assign symRefused   = symRefused_q;
  assign scSel848     = scSel848_q;
  assign scOut        = scOut_q;

  // ========================================================
  // Checks
  logic [10:0] sinceStrobe_q;
  logic [4:0]  bitsSent_q;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sinceStrobe_q <= 11'h000;
      bitsSent_q    <= 5'h00;
    end else begin
      sinceStrobe_q <= symBitStrobe_q ? 11'h000 : sinceStrobe_q + 11'h001;
      if (accept) begin
        bitsSent_q <= 5'h00;
      end else if (symBitStrobe_q) begin
        bitsSent_q <= bitsSent_q + 5'h01;
      end
    end
  end

  property p_upper_sc;
    @(posedge sys_clk) disable iff (!rstn)
      accept && symSel[1] |=> scSel848_q == $past(rate_q.upperPairSubcarrierSel);
  endproperty
  a_upper_sc: assert property (p_upper_sc) else $error("upper subcarrier wrong");

  property p_lower_sc;
    @(posedge sys_clk) disable iff (!rstn)
      accept && !symSel[1] |=> scSel848_q == $past(rate_q.lowerPairSubcarrierSel);
  endproperty
  a_lower_sc: assert property (p_lower_sc) else $error("lower subcarrier wrong");

  property p_rsvd_refused;
    @(posedge sys_clk) disable iff (!rstn)
      symReq && selRsvd |=> symRefused_q && (state_q != txsym_pkg::TXSYM_SEND);
  endproperty
  a_rsvd_refused: assert property (p_rsvd_refused) else $error("reserved rate taken");

  property p_bit_period;
    @(posedge sys_clk) disable iff (!rstn)
      symBitStrobe_q && symBusy && $past(symBusy) |-> sinceStrobe_q == period_q - 11'h001;
  endproperty
  a_bit_period: assert property (p_bit_period) else $error("bit period wrong");

  property p_first0;
    @(posedge sys_clk) disable iff (!rstn)
      accept && symSel == 2'h0 |=> symBit_q == $past(msbOf[0]);
  endproperty
  a_first0: assert property (p_first0) else $error("symbol 0 first bit wrong");

  property p_first1;
    @(posedge sys_clk) disable iff (!rstn)
      accept && symSel == 2'h1 |=> symBit_q == $past(msbOf[1]);
  endproperty
  a_first1: assert property (p_first1) else $error("symbol 1 first bit wrong");

  property p_first2;
    @(posedge sys_clk) disable iff (!rstn)
      accept && symSel == 2'h2 |=> symBit_q == $past(msbOf[2]);
  endproperty
  a_first2: assert property (p_first2) else $error("symbol 2 first bit wrong");

  property p_first3;
    @(posedge sys_clk) disable iff (!rstn)
      accept && symSel == 2'h3 |=> symBit_q == $past(msbOf[3]);
  endproperty
  a_first3: assert property (p_first3) else $error("symbol 3 first bit wrong");

  property p_bit_count;
    @(posedge sys_clk) disable iff (!rstn)
      symDone_q |-> bitsSent_q == {1'b0, lenHeld_q} + 5'h01;
  endproperty
  a_bit_count: assert property (p_bit_count) else $error("bit count wrong");

  property p_len32_rsvd;
    @(posedge sys_clk) disable iff (!rstn)
      regRd && regAddr == `TXSYM_ADDR_LEN32 |=> !regRdata_q[7] && !regRdata_q[3];
  endproperty
  a_len32_rsvd: assert property (p_len32_rsvd) else $error("reserved bit set");

  property p_bit_order;
    @(posedge sys_clk) disable iff (!rstn)
      symBitStrobe_q && symBusy && $past(symBusy) |->
        bitIdx_q == $past(bitIdx_q) - 4'h1 && symBit_q == patt_q[bitIdx_q];
  endproperty
  a_bit_order: assert property (p_bit_order) else $error("bit order wrong");

  c_sym0_done: cover property (@(posedge sys_clk) disable iff (!rstn)
    accept && symSel == 2'h0 ##[1:1000] symDone_q);
  c_sym3_done: cover property (@(posedge sys_clk) disable iff (!rstn)
    accept && symSel == 2'h3 ##[1:1000] symDone_q);
  c_refused: cover property (@(posedge sys_clk) disable iff (!rstn) symRefused_q);
  c_sc_toggle: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(scOut_q));

endmodule : txsym_top

// [verilog/txsym_consts.svh]
// Constants for the transmit symbol pattern definition block
// Notes on behaviour
// - Bit 7 of rate select picks subcarrier for symbols 2/3: 0=424k, 1=848k
// - Bits 6..4 set symbols 2/3 bit rate, codes 2..7 = 26..848 kHz
// - Bit 3 of rate select picks subcarrier for symbols 0/1: 0=424k, 1=848k
// - Bits 2..0 set symbols 0/1 bit rate, same codes; 0 and 1 reserved
// - Symbol 0 pattern is high byte 4Dh joined to low byte 4Eh
// - Symbol 1 pattern is high byte 4Fh joined to low byte 50h
// - Symbol 2 pattern is one read/write byte at 51h
// - Symbol 3 pattern is one read/write byte at 52h
// - Bits 3..0 of 53h give symbol 0 bit count minus one
// - Bits 7..4 of 53h give symbol 1 bit count minus one
// - Bits 2..0 of 54h give symbol 2 bit count minus one; bit 3 reserved
// - Bits 6..4 of 54h give symbol 3 bit count minus one; bit 7 reserved
`ifndef TXSYM_CONSTS_SVH
`define TXSYM_CONSTS_SVH

// ==========================================================
// Register offsets and reset values
`define TXSYM_ADDR_RATE    8'h4c
`define TXSYM_ADDR_P0_HI   8'h4d
`define TXSYM_ADDR_P0_LO   8'h4e
`define TXSYM_ADDR_P1_HI   8'h4f
`define TXSYM_ADDR_P1_LO   8'h50
`define TXSYM_ADDR_P2      8'h51
`define TXSYM_ADDR_P3      8'h52
`define TXSYM_ADDR_LEN10   8'h53
`define TXSYM_ADDR_LEN32   8'h54
`define TXSYM_RESET_BYTE   8'h00
`define TXSYM_LEN32_MASK   8'h77

// ==========================================================
// Rates and cycle counts
`define TXSYM_CLK_HZ       40000000
`define TXSYM_BR_26K       26000
`define TXSYM_BR_53K       53000
`define TXSYM_BR_106K      106000
`define TXSYM_BR_212K      212000
`define TXSYM_BR_424K      424000
`define TXSYM_BR_848K      848000
`define TXSYM_SC_424K      424000
`define TXSYM_SC_848K      848000
`define TXSYM_DIV_26K      (`TXSYM_CLK_HZ / `TXSYM_BR_26K)
`define TXSYM_DIV_53K      (`TXSYM_CLK_HZ / `TXSYM_BR_53K)
`define TXSYM_DIV_106K     (`TXSYM_CLK_HZ / `TXSYM_BR_106K)
`define TXSYM_DIV_212K     (`TXSYM_CLK_HZ / `TXSYM_BR_212K)
`define TXSYM_DIV_424K     (`TXSYM_CLK_HZ / `TXSYM_BR_424K)
`define TXSYM_DIV_848K     (`TXSYM_CLK_HZ / `TXSYM_BR_848K)
`define TXSYM_SCH_424K     (`TXSYM_CLK_HZ / (2 * `TXSYM_SC_424K))
`define TXSYM_SCH_848K     (`TXSYM_CLK_HZ / (2 * `TXSYM_SC_848K))

// ==========================================================
// Bit rate codes
`define TXSYM_CODE_26K     3'h2
`define TXSYM_CODE_53K     3'h3
`define TXSYM_CODE_106K    3'h4
`define TXSYM_CODE_212K    3'h5
`define TXSYM_CODE_424K    3'h6
`define TXSYM_CODE_848K    3'h7

`endif

// [verilog/txsym_pkg.sv]
// Types for the transmit symbol pattern definition block
package txsym_pkg;

  typedef enum logic [1:0] {
    TXSYM_IDLE = 2'b00,
    TXSYM_SEND = 2'b01,
    TXSYM_DONE = 2'b11
  } txsym_state_e;

  typedef struct packed {
    logic       upperPairSubcarrierSel;
    logic [2:0] upperPairBitrateSel;
    logic       lowerPairSubcarrierSel;
    logic [2:0] lowerPairBitrateSel;
  } txsym_rate_s;

  typedef struct packed {
    logic [3:0] secondPatternLength;
    logic [3:0] firstPatternLength;
  } txsym_len10_s;

  typedef struct packed {
    logic       rsvdHi;
    logic [2:0] fourthPatternLength;
    logic       rsvdLo;
    logic [2:0] thirdPatternLength;
  } txsym_len32_s;

endpackage : txsym_pkg

// [testbench/txsym_card_model.sv]
// Card-side receiver model: captures serial symbols and measures bit and subcarrier timing
module txsym_card_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // Serial symbol from the encoder
  input  wire logic        symBusy,
  input  wire logic        symBit,
  input  wire logic        symBitStrobe,
  input  wire logic        scOut,
  // Captured results
  output logic      [15:0] rxBits,
  output logic      [4:0]  rxCount,
  output logic      [11:0] bitPer,
  output logic      [11:0] scHalf
);
  timeunit 1ns;
  timeprecision 1ps;

  logic        busyPrev_q;
  logic        scPrev_q;
  logic [11:0] bitCnt_q;
  logic [11:0] scCnt_q;

  // ==========================================================
  // Capture
  // The first strobe of a symbol restarts the capture, later ones shift in MSB first
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      busyPrev_q <= 1'b0;
      scPrev_q   <= 1'b0;
      bitCnt_q   <= 12'h000;
      scCnt_q    <= 12'h000;
      rxBits     <= 16'h0000;
      rxCount    <= 5'h00;
      bitPer     <= 12'h000;
      scHalf     <= 12'h000;
    end else begin
      busyPrev_q <= symBusy;
      scPrev_q   <= scOut;
      bitCnt_q   <= bitCnt_q + 12'h001;
      scCnt_q    <= scCnt_q + 12'h001;
      if (symBitStrobe) begin
        bitCnt_q <= 12'h001;
        if (!busyPrev_q) begin
          rxBits  <= {15'h0000, symBit};
          rxCount <= 5'h01;
          bitPer  <= 12'h000;
          scHalf  <= 12'h000;
        end else begin
          rxBits  <= {rxBits[14:0], symBit};
          rxCount <= rxCount + 5'h01;
          bitPer  <= bitCnt_q;
        end
      end
      // Only toggles inside a running symbol give a full half period
      if (scOut != scPrev_q) begin
        scCnt_q <= 12'h001;
        if (symBusy && busyPrev_q) begin
          scHalf <= scCnt_q;
        end
      end
    end
  end
endmodule : txsym_card_model

// [testbench/testbench.sv]
// Self-checking testbench for the transmit symbol pattern block
`include "txsym_consts.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk;
  logic        rstn;
  logic [7:0]  regAddr;
  logic [7:0]  regWdata;
  logic        regWr;
  logic        regRd;
  logic [7:0]  regRdata;
  logic        symReq;
  logic [1:0]  symSel;
  logic        symBusy;
  logic        symBit;
  logic        symBitStrobe;
  logic        symDone;
  logic        symRefused;
  logic        scSel848;
  logic        scOut;
  logic [15:0] rxBits;
  logic [4:0]  rxCount;
  logic [11:0] bitPer;
  logic [11:0] scHalf;
  int          err_total;
  int          comparisons;
  int          perTab [8] = '{0, 0, 1538, 754, 377, 188, 94, 47};
  logic [7:0]  wrVal  [9] = '{8'h07, 8'ha5, 8'hc3, 8'h3c, 8'h5a, 8'h96, 8'h81, 8'h4f, 8'hff};

  txsym_top DUT (
    .sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .symReq(symReq), .symSel(symSel), .symBusy(symBusy),
    .symBit(symBit), .symBitStrobe(symBitStrobe), .symDone(symDone),
    .symRefused(symRefused), .scSel848(scSel848), .scOut(scOut)
  );

  txsym_card_model CARD (
    .sys_clk(sys_clk), .rstn(rstn), .symBusy(symBusy), .symBit(symBit),
    .symBitStrobe(symBitStrobe), .scOut(scOut), .rxBits(rxBits), .rxCount(rxCount),
    .bitPer(bitPer), .scHalf(scHalf)
  );

  // ==========================================================
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // Checking and verdict
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    if (err_total == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  // ==========================================================
  // Register port
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge sys_clk);
    regWr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge sys_clk);
    regRd   <= 1'b0;
    #1;
    chk({8'h00, regRdata}, {8'h00, e}, "register read");
  endtask : rd

  // ==========================================================
  // Symbol port
  // Expected state after the request edge is {symBusy, symRefused}
  task automatic start(input logic [1:0] sel, input logic [1:0] st, input logic sc);
    @(posedge sys_clk);
    symSel <= sel;
    symReq <= 1'b1;
    @(posedge sys_clk);
    symReq <= 1'b0;
    #1;
    chk({14'h0000, symBusy, symRefused}, {14'h0000, st}, "request answer");
    if (st[1]) begin
      chk({15'h0000, scSel848}, {15'h0000, sc}, "subcarrier select");
    end
  endtask : start

  task automatic finish(input logic [15:0] bits, input logic [15:0] cnt,
                        input logic [15:0] per, input logic [15:0] half);
    int i;
    for (i = 0; i < 4000; i++) begin
      @(posedge sys_clk);
      #1;
      if (symDone === 1'b1) begin
        break;
      end
    end
    chk({15'h0000, symDone}, 16'h0001, "symbol completion");
    if (symDone !== 1'b1) begin
      report_and_stop();
    end else begin
      chk(rxBits, bits, "symbol bits");
      chk({11'h000, rxCount}, cnt, "bit count");
      chk({4'h0, bitPer}, per, "bit period");
      chk({4'h0, scHalf}, half, "subcarrier half period");
      @(posedge sys_clk);
    end
  endtask : finish

  // ==========================================================
  // Main sequence
  initial begin
    rstn        = 1'b0;
    regAddr     = 8'h00;
    regWdata    = 8'h00;
    regWr       = 1'b0;
    regRd       = 1'b0;
    symReq      = 1'b0;
    symSel      = 2'h0;
    err_total   = 0;
    comparisons = 0;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    for (int a = 8'h4c; a <= 8'h54; a++) begin
      rd(a[7:0], `TXSYM_RESET_BYTE);
    end
    for (int a = 0; a < 9; a++) begin
      wr(8'h4c + a[7:0], wrVal[a]);
    end
    for (int a = 0; a < 8; a++) begin
      rd(8'h4c + a[7:0], wrVal[a]);
    end
    rd(`TXSYM_ADDR_LEN32, 8'h77);
    wr(8'h55, 8'hff);
    rd(8'h55, 8'h00);
    rd(8'h4b, 8'h00);
    // Lower pair at the fastest rate, upper pair on a reserved code
    start(2'h0, 2'b10, 1'b0);
    finish(16'ha5c3, 16'd16, 16'd47, 16'd47);
    start(2'h1, 2'b10, 1'b0);
    finish(16'h001a, 16'd5, 16'd47, 16'd47);
    start(2'h2, 2'b01, 1'b0);
    wr(`TXSYM_ADDR_RATE, 8'hff);
    start(2'h2, 2'b10, 1'b1);
    finish(16'h0096, 16'd8, 16'd47, 16'd23);
    wr(`TXSYM_ADDR_LEN32, 8'h05);
    start(2'h3, 2'b10, 1'b1);
    finish(16'h0001, 16'd1, 16'd0, 16'd23);
    // Busy refusal and pattern latched at acceptance
    start(2'h0, 2'b10, 1'b1);
    start(2'h1, 2'b11, 1'b1);
    wr(`TXSYM_ADDR_P0_HI, 8'h00);
    finish(16'ha5c3, 16'd16, 16'd47, 16'd23);
    // Every bit rate code on both pairs
    wr(`TXSYM_ADDR_LEN10, 8'h11);
    wr(`TXSYM_ADDR_LEN32, 8'h11);
    for (int c = 2; c < 8; c++) begin
      wr(`TXSYM_ADDR_RATE, {1'b0, c[2:0], 1'b1, c[2:0]});
      start(2'h0, 2'b10, 1'b1);
      finish(16'h0003, 16'd2, perTab[c][15:0], 16'd23);
      start(2'h2, 2'b10, 1'b0);
      finish(16'h0002, 16'd2, perTab[c][15:0], 16'd47);
    end
    // Reserved codes are refused on both pairs
    for (int c = 0; c < 2; c++) begin
      wr(`TXSYM_ADDR_RATE, {1'b0, c[2:0], 1'b0, c[2:0]});
      start(2'h1, 2'b01, 1'b0);
      start(2'h3, 2'b01, 1'b0);
    end
    report_and_stop();
  end
endmodule : testbench
